/* File: shared/fpb_pkg.sv */
// Purpose: Shared constants for the flash protection and boot mapping block
// Assumes: APB register window of 4 KB, byte offsets
// Notes: Offsets are byte addresses of aligned 32-bit words
`default_nettype none
package fpb_pkg;
    // Flash geometry
    localparam int PAGE_BYTES = 256;
    localparam int PAGES_MAX = 1024;
    localparam int PAGE_W = 10;
    localparam int LOCK_PAGES = 64;
    localparam int LOCK_SHIFT = 6;
    localparam int LOCKS_MAX = 16;
    localparam int WBUF_BYTES = 128;
    localparam int WBUF_WORDS = 32;
    localparam int WBUF_IDX_LSB = 2;
    localparam int WBUF_IDX_W = 5;
    localparam int GENERAL_NVM_BITS_N = 3;
    localparam int SEC_BIT = 0;
    localparam int BOOT_BIT = 1;
    // Erase pin debounce timing
    localparam int SCLK_HZ = 32768;
    localparam int ERASE_MS = 220;
    localparam int ERASE_TICKS_DOC = (ERASE_MS * SCLK_HZ + 999) / 1000;
    // Register offsets
    localparam logic [11:0] OFS_MODE = 12'h000;
    localparam logic [11:0] OFS_CMD = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_RESULT = 12'h00C;
    localparam logic [11:0] OFS_LOCKS = 12'h010;
    localparam logic [11:0] OFS_GENERAL_NVM_BITS = 12'h014;
    localparam logic [11:0] OFS_CALIB = 12'h018;
    localparam logic [11:0] OFS_UID = 12'h020;
    localparam logic [11:0] OFS_WBUF = 12'h100;
    // Fields
    localparam int MODE_WS_W = 4;
    localparam int MODE_W64_BIT = 4;
    localparam int ST_READY = 0;
    localparam int ST_CMDERR = 1;
    localparam int ST_LOCKERR = 2;
    localparam int CMD_ARG_LSB = 8;
    // Command codes
    localparam logic [7:0] CMD_DESC = 8'h00;
    localparam logic [7:0] CMD_PROG = 8'h01;
    localparam logic [7:0] CMD_ERASE = 8'h02;
    localparam logic [7:0] CMD_ERASE_ALL = 8'h03;
    localparam logic [7:0] CMD_SET_LOCK = 8'h08;
    localparam logic [7:0] CMD_CLR_LOCK = 8'h09;
    localparam logic [7:0] CMD_SET_GP = 8'h0B;
    localparam logic [7:0] CMD_CLR_GP = 8'h0C;
    // Array operations
    localparam logic [1:0] ARR_PROG = 2'h1;
    localparam logic [1:0] ARR_ERASE = 2'h2;
    localparam logic [1:0] ARR_ERASE_ALL = 2'h3;
    // Memory map
    localparam logic [31:0] BOOT_SIZE = 32'h0040_0000;
    localparam logic [31:0] FLASH_BASE = 32'h0040_0000;
    localparam logic [31:0] ROM_BASE = 32'h0080_0000;
    localparam logic [31:0] ROM_SIZE = 32'h0010_0000;
    localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
    localparam logic [31:0] SRAM_SIZE = 32'h0000_6000;
    localparam logic [31:0] ALIAS_BASE = 32'h2200_0000;
    localparam logic [31:0] ALIAS_LAST = 32'h23FF_FFFF;
    typedef enum logic [2:0] {
        MAP_NONE, MAP_BOOT_FLASH, MAP_BOOT_ROM, MAP_FLASH, MAP_ROM, MAP_SRAM, MAP_ALIAS
    } map_region_e;
endpackage
`default_nettype wire

/* File: shared/fpb_sys_if.sv */
// Purpose: Carrier between the core, the erase debouncer and the map decoder
// Assumes: One clock domain
// Notes: Core drives pin level, tick, address and boot choice
`default_nettype none
interface fpb_sys_if;
    logic pin_level;
    logic sclk_tick;
    logic erase_evt;
    logic [31:0] addr;
    logic boot_flash;
    fpb_pkg::map_region_e region;
    logic [31:0] offset;
    modport dbn (input pin_level, input sclk_tick, output erase_evt);
    modport dec (input addr, input boot_flash, output region, output offset);
    modport core (output pin_level, output sclk_tick, output addr, output boot_flash,
                  input erase_evt, input region, input offset);
endinterface
`default_nettype wire

/* File: hdl/erase_debounce.sv */
// Purpose: Debounce the erase pin on slow clock ticks
// Assumes: Pin level and tick already synchronised
// Notes: One pulse per assertion held long enough
`default_nettype none
module erase_debounce #(
    parameter int TICKS = fpb_pkg::ERASE_TICKS_DOC
) (
    input wire logic pclk,
    input wire logic presetn,
    fpb_sys_if.dbn sif
);
    localparam int CW = $clog2(TICKS + 1);
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic fired;
        logic evt;
    } dbn_s;
    dbn_s d_reg, d_next;

    // Count ticks while high, fire once; short pulses never reach the count
    always_comb begin
        d_next = d_reg;
        d_next.evt = 1'b0;
        if (!sif.pin_level) begin
            d_next.cnt = '0;
            d_next.fired = 1'b0;
        end else if (sif.sclk_tick && !d_reg.fired) begin
            if (d_reg.cnt == CW'(TICKS - 1)) begin
                d_next.evt = 1'b1;
                d_next.fired = 1'b1;
            end else begin
                d_next.cnt = d_reg.cnt + 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            d_reg <= '0;
        end else begin
            d_reg <= d_next;
        end
    end

    assign sif.erase_evt = d_reg.evt;
endmodule // erase_debounce
`default_nettype wire

/* File: hdl/boot_map_decode.sv */
// Purpose: Decode a system address into memory regions
// Assumes: Boot choice bit from the core
// Notes: Purely combinational
`default_nettype none
module boot_map_decode (
    fpb_sys_if.dec sif
);
    import fpb_pkg::*;

    // Region select, boot window first
    always_comb begin
        sif.region = MAP_NONE;
        sif.offset = 32'h0000_0000;
        if (sif.addr < BOOT_SIZE) begin
            sif.region = sif.boot_flash ? MAP_BOOT_FLASH : MAP_BOOT_ROM;
            sif.offset = sif.addr;
        end else if (sif.addr >= FLASH_BASE && sif.addr < ROM_BASE) begin
            sif.region = MAP_FLASH;
            sif.offset = sif.addr - FLASH_BASE;
        end else if (sif.addr >= ROM_BASE && sif.addr < ROM_BASE + ROM_SIZE) begin
            sif.region = MAP_ROM;
            sif.offset = sif.addr - ROM_BASE;
        end else if (sif.addr >= SRAM_BASE && sif.addr < SRAM_BASE + SRAM_SIZE) begin
            sif.region = MAP_SRAM;
            sif.offset = sif.addr - SRAM_BASE;
        end else if (sif.addr >= ALIAS_BASE && sif.addr <= ALIAS_LAST) begin
            sif.region = MAP_ALIAS;
            sif.offset = sif.addr - ALIAS_BASE;
        end
    end
endmodule // boot_map_decode
`default_nettype wire

/* File: hdl/flash_protect_boot_map.sv */
// Purpose: Flash controller protection, NVM bits, erase pin and boot mapping
// Assumes: APB slave, one clock; array macro answers arr_req with arr_done
// Notes: NVM bits start from parameter values at reset
// How it works
// - Array is one bank of 256-byte pages, up to 1024 pages.
// - A 128-byte write buffer is filled through 32-bit writes.
// - Software picks 128-bit or 64-bit array read width.
// - Each 64-page region has its own lock bit, up to 16.
// - Program or erase on a locked region aborts and raises an interrupt.
// - Set-lock and clear-lock commands change one lock bit.
// - Erase pin clears every lock bit.
// - Security bit blocks debug and fast programming flash access.
// - Software only sets security; pin erase clears it after full erase.
// - 128-bit unique identifier is read only and survives erase.
// - Calibration bits are read only and survive erase.
// - Test select and port A lines 0 and 1 low enter fast programming.
// - Fast programming port accepts the flash command set.
// - Three NVM bits, each set by command; bits 1 and 2 also cleared by command.
// - NVM bit 1 maps flash or boot ROM at address zero.
// - Erase pin clears NVM bit 1, back to ROM boot.
// - Boot ROM always decodes at its fixed address.
// - SRAM and its bit alias window are decoded.
// - A command returns the flash geometry descriptor.
// - Erase pin is debounced, only long assertions erase.
// - Pin erase runs a full erase leaving all ones.
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`default_nettype none
module flash_protect_boot_map #(
    parameter int PAGES = fpb_pkg::PAGES_MAX,
    parameter int ERASE_TICKS = fpb_pkg::ERASE_TICKS_DOC,
    parameter logic [127:0] UNIQUE_ID = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0, // Arbitrary
    parameter logic [31:0] CALIB_BITS = 32'h0000_0000,
    parameter logic [2:0] GENERAL_NVM_BITS_INIT = 3'h0,
    parameter logic [15:0] LOCK_INIT = 16'h0000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic erase_pin,
    input wire logic sclk_pin,
    input wire logic test_select_pin,
    input wire logic port_a_line0,
    input wire logic port_a_line1,
    input wire logic fpp_cmd_valid,
    input wire logic [7:0] fpp_cmd,
    input wire logic [15:0] fpp_arg,
    output logic fpp_cmd_ready,
    output logic fpp_refused,
    input wire logic dbg_flash_req,
    output logic dbg_flash_grant,
    output logic arr_req,
    output logic [1:0] arr_op,
    output logic [fpb_pkg::PAGE_W-1:0] arr_page,
    input wire logic arr_done,
    input wire logic [fpb_pkg::WBUF_IDX_W-1:0] arr_wbuf_idx,
    output logic [31:0] arr_wbuf_data,
    output logic [fpb_pkg::MODE_WS_W-1:0] rd_wait_states,
    output logic rd_access_64,
    input wire logic [31:0] bus_addr,
    output fpb_pkg::map_region_e map_region,
    output logic [31:0] map_offset,
    output logic fast_prog_mode,
    output logic lock_abort_irq
);
    import fpb_pkg::*;

    localparam int RG_W = PAGE_W - LOCK_SHIFT;
    typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_PIN} fsm_e;
    typedef struct packed {
        logic ers1, ers2, sck1, sck2, sck3;
        logic tst1, tst2, pa0a, pa0b, pa1a, pa1b;
        logic fast_mode, dbg_grant, fpp_ref;
        logic [LOCKS_MAX-1:0] locks;
        logic [GENERAL_NVM_BITS_N-1:0] general_nvm_bits;
        logic [MODE_WS_W-1:0] ws;
        logic w64, cmderr, lockerr, pin_pend, slverr;
        logic [31:0] result;
        logic [31:0] prdata;
        fsm_e fsm;
        logic [1:0] op;
        logic [PAGE_W-1:0] page;
    } state_s;
    state_s s_reg, s_next;
    logic [31:0] wbuf [WBUF_WORDS];
    logic [31:0] wbuf_out_reg;
    logic wr_acc, rd_acc, setup, apb_cmd, fpp_take, idle, sec, wbuf_hit, mapped;
    logic [31:0] rdv;

    fpb_sys_if sif ();

    erase_debounce #(.TICKS(ERASE_TICKS)) u_dbn (
        .pclk(pclk),
        .presetn(presetn),
        .sif(sif.dbn)
    );

    boot_map_decode u_dec (
        .sif(sif.dec)
    );

    // Bus phase decode
    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & penable & ~pwrite;
    assign sec = s_reg.general_nvm_bits[SEC_BIT];
    assign idle = (s_reg.fsm == ST_IDLE) & ~s_reg.pin_pend;
    assign apb_cmd = wr_acc & (paddr == OFS_CMD);
    assign wbuf_hit = (paddr >= OFS_WBUF) && (paddr < OFS_WBUF + 12'(WBUF_BYTES));
    assign fpp_cmd_ready = idle & ~apb_cmd & ~sif.erase_evt & s_reg.fast_mode;
    assign fpp_take = fpp_cmd_valid & fpp_cmd_ready;

    // Geometry descriptor word by index
    function automatic logic [31:0] desc_word(logic [15:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a[2:0])
            3'h0: w = 32'(PAGES * PAGE_BYTES);
            3'h1: w = 32'(PAGE_BYTES);
            3'h2: w = 32'(PAGES);
            3'h3: w = 32'(LOCK_PAGES);
            3'h4: w = 32'(PAGES / LOCK_PAGES);
            3'h5: w = 32'(WBUF_BYTES);
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // Execute one command on a state copy
    function automatic state_s exec_cmd(state_s s, logic [7:0] c, logic [15:0] a);
        state_s n;
        logic [RG_W-1:0] rg;
        logic bad_page;
        n = s;
        rg = a[PAGE_W-1:LOCK_SHIFT];
        bad_page = (a >= 16'(PAGES));
        case (c)
            CMD_PROG, CMD_ERASE: begin
                if (bad_page) begin
                    n.cmderr = 1'b1;
                end else if (s.locks[rg]) begin
                    n.lockerr = 1'b1;
                end else begin
                    n.fsm = ST_BUSY;
                    n.op = (c == CMD_PROG) ? ARR_PROG : ARR_ERASE;
                    n.page = a[PAGE_W-1:0];
                end
            end
            CMD_ERASE_ALL: begin
                if (|s.locks) begin
                    n.lockerr = 1'b1;
                end else begin
                    n.fsm = ST_BUSY;
                    n.op = ARR_ERASE_ALL;
                    n.page = '0;
                end
            end
            CMD_SET_LOCK, CMD_CLR_LOCK: begin
                if (bad_page) begin
                    n.cmderr = 1'b1;
                end else begin
                    n.locks[rg] = (c == CMD_SET_LOCK);
                end
            end
            CMD_SET_GP: begin
                if (a >= 16'(GENERAL_NVM_BITS_N)) begin
                    n.cmderr = 1'b1;
                end else begin
                    n.general_nvm_bits[a[1:0]] = 1'b1;
                end
            end
            CMD_CLR_GP: begin
                if (a >= 16'(GENERAL_NVM_BITS_N) || a == 16'(SEC_BIT)) begin
                    n.cmderr = 1'b1;
                end else begin
                    n.general_nvm_bits[a[1:0]] = 1'b0;
                end
            end
            CMD_DESC: n.result = desc_word(a);
            default: n.cmderr = 1'b1;
        endcase
        return n;
    endfunction

    // Register read mux, identifier and calibration are constants
    always_comb begin
        rdv = 32'h0000_0000;
        mapped = 1'b1;
        if (paddr == OFS_MODE) begin
            rdv = 32'({s_reg.w64, s_reg.ws});
        end else if (paddr == OFS_CMD) begin
            rdv = 32'h0000_0000;
        end else if (paddr == OFS_STATUS) begin
            rdv = 32'({s_reg.lockerr, s_reg.cmderr, idle});
        end else if (paddr == OFS_RESULT) begin
            rdv = s_reg.result;
        end else if (paddr == OFS_LOCKS) begin
            rdv = 32'(s_reg.locks);
        end else if (paddr == OFS_GENERAL_NVM_BITS) begin
            rdv = 32'(s_reg.general_nvm_bits);
        end else if (paddr == OFS_CALIB) begin
            rdv = CALIB_BITS;
        end else if (paddr[11:4] == OFS_UID[11:4]) begin
            rdv = UNIQUE_ID[32 * paddr[3:2] +: 32];
        end else if (!wbuf_hit) begin
            mapped = 1'b0;
        end
    end

    // Next state
    always_comb begin
        s_next = s_reg;
        s_next.ers1 = erase_pin;
        s_next.ers2 = s_reg.ers1;
        s_next.sck1 = sclk_pin;
        s_next.sck2 = s_reg.sck1;
        s_next.sck3 = s_reg.sck2;
        s_next.tst1 = test_select_pin;
        s_next.tst2 = s_reg.tst1;
        s_next.pa0a = port_a_line0;
        s_next.pa0b = s_reg.pa0a;
        s_next.pa1a = port_a_line1;
        s_next.pa1b = s_reg.pa1a;
        s_next.fast_mode = ~(s_reg.tst2 | s_reg.pa0b | s_reg.pa1b);
        s_next.dbg_grant = dbg_flash_req & ~sec;
        s_next.fpp_ref = 1'b0;
        if (wr_acc && paddr == OFS_MODE) begin
            s_next.ws = pwdata[MODE_WS_W-1:0];
            s_next.w64 = pwdata[MODE_W64_BIT];
        end
        // Read clears only the error bits that were reported
        if (rd_acc && paddr == OFS_STATUS) begin
            s_next.cmderr = s_reg.cmderr & ~s_reg.prdata[ST_CMDERR];
            s_next.lockerr = s_reg.lockerr & ~s_reg.prdata[ST_LOCKERR];
        end
        if (s_reg.fsm != ST_IDLE && arr_done) begin
            if (s_reg.fsm == ST_PIN) begin
                s_next.general_nvm_bits[SEC_BIT] = 1'b0;
            end
            s_next.fsm = ST_IDLE;
        end
        // Commands; error sets come after clears so they win
        if (apb_cmd) begin
            if (idle) begin
                s_next = exec_cmd(s_next, pwdata[7:0], pwdata[CMD_ARG_LSB +: 16]);
            end else begin
                s_next.cmderr = 1'b1;
            end
        end else if (fpp_take) begin
            if (sec) begin
                s_next.fpp_ref = 1'b1;
            end else begin
                s_next = exec_cmd(s_next, fpp_cmd, fpp_arg);
            end
        end
        if (sif.erase_evt) begin
            s_next.locks = '0;
            s_next.general_nvm_bits[BOOT_BIT] = 1'b0;
            s_next.pin_pend = 1'b1;
        end
        if (s_reg.pin_pend && s_reg.fsm == ST_IDLE) begin
            s_next.fsm = ST_PIN;
            s_next.op = ARR_ERASE_ALL;
            s_next.page = '0;
            s_next.pin_pend = 1'b0;
        end
        if (setup) begin
            s_next.prdata = pwrite ? 32'h0000_0000 : rdv;
            s_next.slverr = ~mapped;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            s_reg.locks <= LOCK_INIT;
            s_reg.general_nvm_bits <= GENERAL_NVM_BITS_INIT;
            s_reg.fsm <= ST_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // Write buffer fill, 32-bit words
    always_ff @(posedge pclk) begin
        if (wr_acc && wbuf_hit) begin
            wbuf[paddr[WBUF_IDX_LSB +: WBUF_IDX_W]] <= pwdata;
        end
    end

    // Buffer read port for the array
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wbuf_out_reg <= 32'h0000_0000;
        end else begin
            wbuf_out_reg <= wbuf[arr_wbuf_idx];
        end
    end

    // Outputs
    assign sif.pin_level = s_reg.ers2;
    assign sif.sclk_tick = s_reg.sck2 & ~s_reg.sck3;
    assign sif.addr = bus_addr;
    assign sif.boot_flash = s_reg.general_nvm_bits[BOOT_BIT];
    assign map_region = sif.region;
    assign map_offset = sif.offset;
    assign prdata = s_reg.prdata;
    assign pready = psel & penable;
    assign pslverr = psel & penable & s_reg.slverr;
    assign fpp_refused = s_reg.fpp_ref;
    assign dbg_flash_grant = s_reg.dbg_grant;
    assign arr_req = (s_reg.fsm != ST_IDLE);
    assign arr_op = s_reg.op;
    assign arr_page = s_reg.page;
    assign arr_wbuf_data = wbuf_out_reg;
    assign rd_wait_states = s_reg.ws;
    assign rd_access_64 = s_reg.w64;
    assign fast_prog_mode = s_reg.fast_mode;
    assign lock_abort_irq = s_reg.lockerr;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_LOCK_ABORT: assert property (
        (apb_cmd && idle && pwdata[7:0] == CMD_PROG && pwdata[CMD_ARG_LSB +: 16] < 16'(PAGES)
         && s_reg.locks[pwdata[CMD_ARG_LSB + LOCK_SHIFT +: RG_W]] && !sif.erase_evt)
        |=> lock_abort_irq && !arr_req)
        else $error("locked program not aborted");
    AST_PIN_LOCKS: assert property (sif.erase_evt |=> s_reg.locks == '0)
        else $error("erase event left a lock set");
    AST_PIN_BOOT: assert property (sif.erase_evt |=> !s_reg.general_nvm_bits[BOOT_BIT])
        else $error("erase event left flash boot");
    AST_SEC_DBG: assert property (sec |=> !dbg_flash_grant)
        else $error("debug granted while secure");
    AST_SEC_FPP: assert property (fpp_take && sec |=> fpp_refused && $stable(s_reg.locks))
        else $error("secure fast programming command not refused");
    AST_SEC_CLEAR: assert property ($fell(sec) |-> $past(s_reg.fsm) == ST_PIN && $past(arr_done))
        else $error("security cleared outside pin erase");
    AST_EVT_PULSE: assert property (sif.erase_evt |=> !sif.erase_evt)
        else $error("erase event longer than one cycle");
    AST_PIN_ERASE: assert property (sif.erase_evt ##1 (s_reg.fsm == ST_IDLE)
        |=> arr_req && arr_op == ARR_ERASE_ALL)
        else $error("pin erase not started");
    AST_FAST_MODE: assert property (!s_reg.tst2 && !s_reg.pa0b && !s_reg.pa1b
        |=> fast_prog_mode)
        else $error("fast programming mode not entered");
    AST_WIDTH: assert property (wr_acc && paddr == OFS_MODE
        |=> rd_access_64 == $past(pwdata[MODE_W64_BIT]))
        else $error("access width not updated");
    AST_BOOT_MAP: assert property (bus_addr < BOOT_SIZE
        |-> map_region == (s_reg.general_nvm_bits[BOOT_BIT] ? MAP_BOOT_FLASH : MAP_BOOT_ROM))
        else $error("boot window decode wrong");
    AST_ROM_FIXED: assert property (bus_addr == ROM_BASE |-> map_region == MAP_ROM)
        else $error("rom not at fixed address");

    COV_ABORT: cover property ($rose(lock_abort_irq));
    COV_PIN_DONE: cover property (s_reg.fsm == ST_PIN ##1 s_reg.fsm == ST_IDLE);
    COV_FPP: cover property (fpp_take && !sec);
    COV_FLASH_BOOT: cover property (map_region == MAP_BOOT_FLASH);
endmodule // flash_protect_boot_map
`default_nettype wire

/* File: sim/array_model.sv */
// Purpose: Flash array stand-in that answers array requests
// Assumes: One clock; done is a one-cycle pulse while the request stands
// Notes: The delay input picks a prompt or a slow answer
`default_nettype none
module array_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic arr_req,
    input wire logic [3:0] delay,
    output logic arr_done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_reg;
    // Count the wait, then pulse done once per request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 4'h0;
            arr_done <= 1'b0;
        end else begin
            arr_done <= arr_req && !arr_done && cnt_reg == delay;
            cnt_reg <= (arr_req && !arr_done && cnt_reg != delay) ? cnt_reg + 4'h1 : 4'h0;
        end
    end
endmodule // array_model
`default_nettype wire

/* File: sim/flash_protect_boot_map_bench.sv */
// Purpose: Self-checking bench for the flash protection and boot map block
// Assumes: Array model answers requests; the slow clock is divided from pclk
// Notes: Bus results are queued by the driver and compared by a watcher
`default_nettype none
module flash_protect_boot_map_bench import fpb_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [127:0] UID = 128'h1111_2222_3333_4444_5555_6666_7777_8888; // Arbitrary
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, bus_addr = 32'h0, prdata, arr_wbuf_data, map_offset;
    logic pready, pslverr, erase_pin = 1'b0, sclk_pin, test_select_pin = 1'b1;
    logic port_a_line0 = 1'b1, port_a_line1 = 1'b1, fpp_cmd_valid = 1'b0, fpp_cmd_ready;
    logic [7:0] fpp_cmd = 8'h00;
    logic [15:0] fpp_arg = 16'h0000;
    logic fpp_refused, dbg_flash_req = 1'b1, dbg_flash_grant, arr_req, arr_done;
    logic [1:0] arr_op;
    logic [9:0] arr_page;
    logic [4:0] arr_wbuf_idx = 5'h00;
    logic [3:0] rd_wait_states, dly = 4'h0;
    logic rd_access_64, fast_prog_mode, lock_abort_irq;
    map_region_e map_region;
    logic [2:0] sdiv = 3'h0;
    logic [33:0] e;
    logic [33:0] exp_q [$];
    int fail_count = 0, samples_checked = 0, cycles = 0;
    flash_protect_boot_map #(.ERASE_TICKS(4), .UNIQUE_ID(UID)) flash_protect_boot_map_inst (.*);
    array_model array_model_inst (.pclk, .presetn, .arr_req, .delay(dly), .arr_done);
    // Clock, slow clock divider and run limit
    always #25 pclk = ~pclk;
    assign sclk_pin = sdiv[2];
    always @(posedge pclk) begin
        sdiv <= sdiv + 3'h1;
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            summarize();
        end
    end
    task automatic summarize();
        if (fail_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Watcher: each completed bus transfer is compared with the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready) begin
            e = exp_q.pop_front();
            check({pslverr, e[33] ? 32'h0 : prdata}, e[32:0]);
        end
    end
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] exp);
        exp_q.push_back({wr, exp});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic cmd(input logic [7:0] c, input logic [15:0] g);
        apb(1'b1, OFS_CMD, {8'h00, g, c}, 33'h0);
    endtask
    task automatic fpp(input logic [7:0] c, input logic [15:0] g);
        fpp_cmd_valid <= 1'b1;
        fpp_cmd <= c;
        fpp_arg <= g;
        do @(posedge pclk); while (fpp_cmd_ready !== 1'b1);
        fpp_cmd_valid <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_busy(input logic lvl);
        while (arr_req !== lvl) @(posedge pclk);
    endtask
    // Main sequence
    initial begin
        logic [9:0] pg;
        logic [31:0] w;
        logic [31:0] desc [6];
        logic [31:0] adr [4];
        map_region_e reg_exp [4];
        void'($urandom(32'h424e2b55));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        pg = 10'($urandom);
        w = $urandom;
        check(33'(dbg_flash_grant), 33'h1);
        apb(1'b1, OFS_MODE, {27'h0, pg[4:0]}, 33'h0);
        check(33'({rd_access_64, rd_wait_states}), 33'(pg[4:0]));
        apb(1'b1, 12'h0FC, w, {1'b1, 32'h0});
        apb(1'b1, OFS_WBUF + {5'h0, pg[4:0], 2'h0}, w, 33'h0);
        arr_wbuf_idx <= pg[4:0];
        repeat (2) @(posedge pclk);
        check(33'(arr_wbuf_data), 33'(w));
        desc = '{32'h40000, 32'h100, 32'h400, 32'h40, 32'h10, 32'h80};
        foreach (desc[i]) begin
            cmd(CMD_DESC, 16'(i));
            apb(1'b0, OFS_RESULT, 32'h0, {1'b0, desc[i]});
        end
        cmd(CMD_SET_LOCK, {6'h0, pg});
        apb(1'b0, OFS_LOCKS, 32'h0, {1'b0, 32'h1 << pg[9:6]});
        cmd(CMD_PROG, {6'h0, pg});
        check(33'({lock_abort_irq, arr_req}), 33'h2);
        apb(1'b0, OFS_STATUS, 32'h0, 33'h5);
        check(33'(lock_abort_irq), 33'h0);
        dly <= 4'($urandom);
        cmd(CMD_PROG, {6'h0, pg ^ 10'h200});
        wait_busy(1'b1);
        check(33'({arr_op, arr_page}), 33'({ARR_PROG, pg ^ 10'h200}));
        wait_busy(1'b0);
        cmd(CMD_CLR_LOCK, {6'h0, pg});
        apb(1'b0, OFS_LOCKS, 32'h0, 33'h0);
        cmd(CMD_SET_GP, 16'h1);
        apb(1'b0, OFS_GENERAL_NVM_BITS, 32'h0, 33'h2);
        adr = '{32'h0, ROM_BASE, SRAM_BASE, 32'h2200_0000 | 32'($urandom) & 32'h01FF_FFFF};
        reg_exp = '{MAP_BOOT_FLASH, MAP_ROM, MAP_SRAM, MAP_ALIAS};
        foreach (adr[i]) begin
            bus_addr <= adr[i];
            @(posedge pclk);
            check(33'(map_region), 33'(reg_exp[i]));
        end
        cmd(CMD_CLR_GP, 16'h1);
        check(33'(map_region), 33'(MAP_ALIAS));
        check(33'(map_offset), 33'(adr[3] - ALIAS_BASE));
        bus_addr <= 32'h0;
        @(posedge pclk);
        check(33'(map_region), 33'(MAP_BOOT_ROM));
        cmd(CMD_SET_GP, 16'h0);
        @(posedge pclk);
        check(33'(dbg_flash_grant), 33'h0);
        cmd(CMD_CLR_GP, 16'h0);
        apb(1'b0, OFS_STATUS, 32'h0, 33'h3);
        cmd(CMD_SET_LOCK, {6'h0, pg});
        cmd(CMD_ERASE_ALL, 16'h0);
        apb(1'b0, OFS_STATUS, 32'h0, 33'h5);
        cmd(CMD_SET_GP, 16'h1);
        // A short pulse must leave everything in place
        erase_pin <= 1'b1;
        repeat (16) @(posedge pclk);
        erase_pin <= 1'b0;
        repeat (16) @(posedge pclk);
        apb(1'b0, OFS_GENERAL_NVM_BITS, 32'h0, 33'h3);
        erase_pin <= 1'b1;
        wait_busy(1'b1);
        check(33'(arr_op), 33'(ARR_ERASE_ALL));
        wait_busy(1'b0);
        repeat (40) @(posedge pclk);
        erase_pin <= 1'b0;
        apb(1'b0, OFS_LOCKS, 32'h0, 33'h0);
        apb(1'b0, OFS_GENERAL_NVM_BITS, 32'h0, 33'h0);
        apb(1'b0, OFS_UID, 32'h0, {1'b0, UID[31:0]});
        apb(1'b0, OFS_CALIB, 32'h0, 33'h0);
        check(33'(dbg_flash_grant), 33'h1);
        test_select_pin <= 1'b0;
        port_a_line0 <= 1'b0;
        port_a_line1 <= 1'b0;
        repeat (4) @(posedge pclk);
        check(33'(fast_prog_mode), 33'h1);
        fpp(CMD_ERASE, {6'h0, pg});
        check(33'({arr_req, arr_op, fpp_refused}), 33'({1'b1, ARR_ERASE, 1'b0}));
        wait_busy(1'b0);
        fpp(CMD_SET_GP, 16'h0);
        fpp(CMD_CLR_LOCK, 16'h0);
        check(33'({fpp_refused, dbg_flash_grant}), 33'h2);
        summarize();
    end
endmodule // flash_protect_boot_map_bench
`default_nettype wire
